// file: shared/bsi_params.svh
// constants for the boundary-scan instruction logic
`ifndef BSI_PARAMS_SVH
`define BSI_PARAMS_SVH

`define BSI_IR_W 3
`define BSI_IR_EXTEST 3'h0
`define BSI_IR_IDCODE 3'h1
`define BSI_IR_SAMPZ 3'h2
`define BSI_IR_SAMPLE 3'h4
`define BSI_IR_BYPASS 3'h7
`define BSI_IR_CAPT 2'h1
`define BSI_BSR_W 73
`define BSI_ID_W 32
`define BSI_ID_VALUE 32'h1357_9bdf // arbitrary value; bit 0 set marks an id register
`define BSI_FIFO_W 1
`define BSI_FIFO_D 16
`define BSI_RST_EDGES 5

`endif

// file: shared/bsi_pkg.sv
// types shared by the boundary-scan instruction logic
package bsi_pkg;

    typedef enum logic [3:0] {
        TLR, RTI, SEL_DR, CAP_DR, SH_DR, EX1_DR, PAU_DR, EX2_DR, UPD_DR,
        SEL_IR, CAP_IR, SH_IR, EX1_IR, PAU_IR, EX2_IR, UPD_IR
    } bsi_tap_t;

endpackage

// file: src/bsi_fifo.sv
// small valid/ready fifo on the captured-ring data path
`timescale 1ns/1ps
module bsi_fifo #(
    parameter int W = 1,
    parameter int D = 16
) (
    // clock and reset
    input wire logic sys_clk_i,
    input wire logic rst_n_i,
    // fill side
    input wire logic in_valid_i,
    output logic in_ready_o,
    input wire logic [W-1:0] in_data_i,
    // drain side
    output logic out_valid_o,
    input wire logic out_ready_i,
    output logic [W-1:0] out_data_o
);
    localparam int AW = $clog2(D);

    logic [W-1:0] mem_q [D];
    logic [AW:0] wp_q;
    logic [AW:0] rp_q;
    logic full;
    logic empty;

    // full when pointers differ only in the wrap bit
    assign empty = (wp_q == rp_q);
    assign full = (wp_q[AW] != rp_q[AW]) && (wp_q[AW-1:0] == rp_q[AW-1:0]);
    assign in_ready_o = !full;
    assign out_valid_o = !empty;
    assign out_data_o = mem_q[rp_q[AW-1:0]];

    // pointer update
    always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            wp_q <= '0;
            rp_q <= '0;
        end else begin
            if (in_valid_i && !full) begin
                wp_q <= wp_q + 1'b1;
            end
            if (out_ready_i && !empty) begin
                rp_q <= rp_q + 1'b1;
            end
        end
    end

    // storage, no reset needed
    always_ff @(posedge sys_clk_i) begin
        if (in_valid_i && !full) begin
            mem_q[wp_q[AW-1:0]] <= in_data_i;
        end
    end
endmodule

// file: src/bsi_tap.sv
// boundary-scan instruction decode and data-register selection
// How it works
// - three-bit instruction register; eight codes, five used, three reserved
// - port never drives core or preloads i/o buffers
// - extest, sample-z, sample only capture the i/o ring
// - shift-ir shifts instruction register one bit per test clock
// - new instruction takes effect only at update-ir
// - all-zero code decodes as valid external test
// - external test equals sample but forces outputs high impedance
// - identification loads fixed 32-bit code in capture-dr, shifts out
// - power-up and test-logic-reset load identification instruction
// - high-z sample selects boundary register and forces outputs high-z
// - sample captures every input and bidirectional ball in capture-dr
// - boundary register shifts captured bits out in shift-dr
// - update-dr under sample changes nothing, like pause-dr
// - bypass selects the single-bit bypass register
// - codes: extest 000, id 001, sample-z 010, sample 100, bypass 111
// - capture-ir loads 01 into the two low bits
// - boundary register 73 bits wide config, 54 bits narrow
// - five tms-high rising edges reach test-logic-reset
`timescale 1ns/1ps
`include "bsi_params.svh"
module bsi_tap (
    // clock and reset
    input wire logic sys_clk_i,
    input wire logic rst_n_i,
    // test port pins
    input wire logic tck_i,
    input wire logic tms_i,
    input wire logic tdi_i,
    output logic tdo_o,
    output logic tdo_oe_o,
    // configuration strap: high for the 73-bit ring
    input wire logic wide_cfg_i,
    // i/o ring sense, bit 0 nearest tdo
    input wire logic [`BSI_BSR_W-1:0] ring_i,
    // memory output-driver gate
    output logic mem_hiz_o,
    // captured ring stream, one bit per word
    output logic cap_valid_o,
    input wire logic cap_ready_i,
    output logic cap_data_o
);
    // ------------------------------------------------------------
    // state
    // ------------------------------------------------------------
    typedef struct packed {
        logic [2:0] tck_s;
        logic [2:0] tms_s;
        logic [2:0] tdi_s;
        logic tck_lvl;
        logic tms_lvl;
        logic tdi_lvl;
        bsi_pkg::bsi_tap_t st;
        logic [`BSI_IR_W-1:0] ir_sh;
        logic [`BSI_IR_W-1:0] ir;
        logic [`BSI_ID_W-1:0] id_sh;
        logic [`BSI_BSR_W-1:0] bsr;
        // stream copy, kept apart from the shifting ring
        logic [`BSI_BSR_W-1:0] snap;
        logic byp;
        logic tdo;
        logic tdo_oe;
        logic wide;
        logic wide_ok;
        logic [6:0] cap_cnt;
    } bsi_state_t;

    bsi_state_t s_q;
    bsi_state_t s_d;
    logic tck_rise;
    logic tck_fall;
    logic fifo_ready;
    logic [6:0] ring_len;

    // decode helpers for the path mux and the capture-dr load; the hiz gate decodes ir directly
    // ring-path decode
    function automatic logic sel_bsr(input logic [2:0] ir);
        sel_bsr = (ir == `BSI_IR_EXTEST) || (ir == `BSI_IR_SAMPZ) || (ir == `BSI_IR_SAMPLE);
    endfunction

    function automatic logic [2:0] rd_tdo(input bsi_state_t s);
        if (s.st == bsi_pkg::SH_IR) begin
            rd_tdo = {2'h0, s.ir_sh[0]};
        end else if (s.ir == `BSI_IR_IDCODE) begin
            rd_tdo = {2'h0, s.id_sh[0]};
        end else if (sel_bsr(s.ir)) begin
            rd_tdo = {2'h0, s.bsr[0]};
        end else begin
            rd_tdo = {2'h0, s.byp};
        end
    endfunction

    // edges only from agreeing 2nd and 3rd stages
    assign tck_rise = (s_q.tck_s[2] == s_q.tck_s[1]) && s_q.tck_s[1] && !s_q.tck_lvl;
    assign tck_fall = (s_q.tck_s[2] == s_q.tck_s[1]) && !s_q.tck_s[1] && s_q.tck_lvl;
    assign ring_len = s_q.wide ? 7'd73 : 7'd54;

    // ------------------------------------------------------------
    // next state
    // ------------------------------------------------------------
    always_comb begin
        logic [2:0] nb;
        nb = '0;
        s_d = s_q;
        s_d.tck_s = {s_q.tck_s[1:0], tck_i};
        s_d.tms_s = {s_q.tms_s[1:0], tms_i};
        s_d.tdi_s = {s_q.tdi_s[1:0], tdi_i};
        if (s_q.tck_s[2] == s_q.tck_s[1]) begin
            s_d.tck_lvl = s_q.tck_s[1];
        end
        if (s_q.tms_s[2] == s_q.tms_s[1]) begin
            s_d.tms_lvl = s_q.tms_s[1];
        end
        if (s_q.tdi_s[2] == s_q.tdi_s[1]) begin
            s_d.tdi_lvl = s_q.tdi_s[1];
        end
        // strap taken once after reset release
        if (!s_q.wide_ok) begin
            s_d.wide = wide_cfg_i;
            s_d.wide_ok = 1'b1;
        end
        // stream captured bits into fifo, stalls when full
        if (s_q.cap_cnt != 7'd0 && fifo_ready) begin
            s_d.cap_cnt = s_q.cap_cnt - 7'd1;
        end
        if (tck_rise) begin
            // data action in the current state
            unique case (s_q.st)
                bsi_pkg::TLR: begin
                    s_d.ir = `BSI_IR_IDCODE;
                end
                bsi_pkg::CAP_IR: begin
                    s_d.ir_sh = {s_q.ir[2], `BSI_IR_CAPT};
                end
                bsi_pkg::SH_IR: begin
                    s_d.ir_sh = {s_q.tdi_lvl, s_q.ir_sh[2:1]};
                end
                bsi_pkg::UPD_IR: begin
                    s_d.ir = s_q.ir_sh;
                end
                bsi_pkg::CAP_DR: begin
                    s_d.id_sh = `BSI_ID_VALUE;
                    s_d.byp = 1'b0;
                    if (sel_bsr(s_q.ir)) begin
                        s_d.bsr = ring_i;
                        s_d.snap = ring_i;
                        s_d.cap_cnt = ring_len;
                    end
                end
                bsi_pkg::SH_DR: begin
                    // tdi enters at the active length
                    s_d.id_sh = {s_q.tdi_lvl, s_q.id_sh[31:1]};
                    s_d.byp = s_q.tdi_lvl;
                    s_d.bsr = s_q.bsr >> 1;
                    s_d.bsr[ring_len - 7'd1] = s_q.tdi_lvl;
                end
                default: begin
                    s_d.bsr = s_q.bsr;
                end
            endcase
            // standard state walk; five tms highs reach reset
            unique case (s_q.st)
                bsi_pkg::TLR: s_d.st = s_q.tms_lvl ? bsi_pkg::TLR : bsi_pkg::RTI;
                bsi_pkg::RTI: s_d.st = s_q.tms_lvl ? bsi_pkg::SEL_DR : bsi_pkg::RTI;
                bsi_pkg::SEL_DR: s_d.st = s_q.tms_lvl ? bsi_pkg::SEL_IR : bsi_pkg::CAP_DR;
                bsi_pkg::CAP_DR: s_d.st = s_q.tms_lvl ? bsi_pkg::EX1_DR : bsi_pkg::SH_DR;
                bsi_pkg::SH_DR: s_d.st = s_q.tms_lvl ? bsi_pkg::EX1_DR : bsi_pkg::SH_DR;
                bsi_pkg::EX1_DR: s_d.st = s_q.tms_lvl ? bsi_pkg::UPD_DR : bsi_pkg::PAU_DR;
                bsi_pkg::PAU_DR: s_d.st = s_q.tms_lvl ? bsi_pkg::EX2_DR : bsi_pkg::PAU_DR;
                bsi_pkg::EX2_DR: s_d.st = s_q.tms_lvl ? bsi_pkg::UPD_DR : bsi_pkg::SH_DR;
                bsi_pkg::UPD_DR: s_d.st = s_q.tms_lvl ? bsi_pkg::SEL_DR : bsi_pkg::RTI;
                bsi_pkg::SEL_IR: s_d.st = s_q.tms_lvl ? bsi_pkg::TLR : bsi_pkg::CAP_IR;
                bsi_pkg::CAP_IR: s_d.st = s_q.tms_lvl ? bsi_pkg::EX1_IR : bsi_pkg::SH_IR;
                bsi_pkg::SH_IR: s_d.st = s_q.tms_lvl ? bsi_pkg::EX1_IR : bsi_pkg::SH_IR;
                bsi_pkg::EX1_IR: s_d.st = s_q.tms_lvl ? bsi_pkg::UPD_IR : bsi_pkg::PAU_IR;
                bsi_pkg::PAU_IR: s_d.st = s_q.tms_lvl ? bsi_pkg::EX2_IR : bsi_pkg::PAU_IR;
                bsi_pkg::EX2_IR: s_d.st = s_q.tms_lvl ? bsi_pkg::UPD_IR : bsi_pkg::SH_IR;
                bsi_pkg::UPD_IR: s_d.st = s_q.tms_lvl ? bsi_pkg::SEL_DR : bsi_pkg::RTI;
            endcase
            // id on entering reset, so a stopped clock leaves no gate set
            if (s_d.st == bsi_pkg::TLR) begin
                s_d.ir = `BSI_IR_IDCODE;
            end
        end
        // tdo launched on falling edge, driven in shift states only
        if (tck_fall) begin
            nb = rd_tdo(s_q);
            s_d.tdo = nb[0];
            s_d.tdo_oe = (s_q.st == bsi_pkg::SH_IR) || (s_q.st == bsi_pkg::SH_DR);
        end
    end

    // ------------------------------------------------------------
    // registers
    // ------------------------------------------------------------
    always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            s_q <= '0;
            s_q.st <= bsi_pkg::TLR;
            s_q.ir <= `BSI_IR_IDCODE;
            // pulled-up pins idle high, so a parked-high clock cannot walk the port
            s_q.tms_s <= '1;
            s_q.tms_lvl <= 1'b1;
            s_q.tdi_s <= '1;
            s_q.tdi_lvl <= 1'b1;
        end else begin
            s_q <= s_d;
        end
    end

    // captured ring leaves lsb first through the fifo, from the copy so a stall survives shifting
    bsi_fifo #(.W(`BSI_FIFO_W), .D(`BSI_FIFO_D)) u_fifo (
        .sys_clk_i(sys_clk_i),
        .rst_n_i(rst_n_i),
        .in_valid_i(s_q.cap_cnt != 7'd0),
        .in_ready_o(fifo_ready),
        .in_data_i(s_q.snap[ring_len - s_q.cap_cnt]),
        .out_valid_o(cap_valid_o),
        .out_ready_i(cap_ready_i),
        .out_data_o(cap_data_o)
    );

    // ------------------------------------------------------------
    // outputs
    // ------------------------------------------------------------
    assign tdo_o = s_q.tdo;
    assign tdo_oe_o = s_q.tdo_oe;
    // outputs released under extest and sample-z
    assign mem_hiz_o = (s_q.ir == `BSI_IR_EXTEST) || (s_q.ir == `BSI_IR_SAMPZ);

    // ------------------------------------------------------------
    // checks
    // ------------------------------------------------------------
    // reset loads id
    a_reset_loads_id: assert property (@(posedge sys_clk_i) disable iff (!rst_n_i)
        tck_rise && s_q.st == bsi_pkg::TLR |=> s_q.ir == `BSI_IR_IDCODE) else $error("id not loaded in reset");
    a_tlr_holds_id: assert property (@(posedge sys_clk_i) disable iff (!rst_n_i)
        s_q.st == bsi_pkg::TLR |-> s_q.ir == `BSI_IR_IDCODE) else $error("reset state without id");
    a_update_ir_only: assert property (@(posedge sys_clk_i) disable iff (!rst_n_i)
        s_q.ir != $past(s_q.ir) |-> $past(s_q.st) == bsi_pkg::UPD_IR || s_q.st == bsi_pkg::TLR)
        else $error("ir moved");
    a_capture_ir_pat: assert property (@(posedge sys_clk_i) disable iff (!rst_n_i)
        tck_rise && s_q.st == bsi_pkg::CAP_IR |=> s_q.ir_sh[1:0] == 2'h1) else $error("capture-ir pattern");
    a_ir_shift_step: assert property (@(posedge sys_clk_i) disable iff (!rst_n_i)
        tck_rise && s_q.st == bsi_pkg::SH_IR |=> s_q.ir_sh == {$past(s_q.tdi_lvl), $past(s_q.ir_sh[2:1])})
        else $error("ir shift step");
    a_hiz_decode: assert property (@(posedge sys_clk_i) disable iff (!rst_n_i)
        mem_hiz_o == (s_q.ir == 3'h0 || s_q.ir == 3'h2)) else $error("hiz decode");
    a_sampz_path: assert property (@(posedge sys_clk_i) disable iff (!rst_n_i)
        tck_fall && s_q.st == bsi_pkg::SH_DR && s_q.ir == `BSI_IR_SAMPZ |=> tdo_o == $past(s_q.bsr[0]))
        else $error("sample-z path");
    a_extest_capture: assert property (@(posedge sys_clk_i) disable iff (!rst_n_i)
        tck_rise && s_q.st == bsi_pkg::CAP_DR && s_q.ir == `BSI_IR_EXTEST |=> s_q.bsr == $past(ring_i))
        else $error("extest capture");
    a_id_capture: assert property (@(posedge sys_clk_i) disable iff (!rst_n_i)
        tck_rise && s_q.st == bsi_pkg::CAP_DR |=> s_q.id_sh == `BSI_ID_VALUE) else $error("id capture");
    a_tdo_idle_hiz: assert property (@(posedge sys_clk_i) disable iff (!rst_n_i)
        tck_fall && !(s_q.st inside {bsi_pkg::SH_IR, bsi_pkg::SH_DR}) |=> !tdo_oe_o) else $error("tdo driven");
    a_tdo_shift_drv: assert property (@(posedge sys_clk_i) disable iff (!rst_n_i)
        tck_fall && s_q.st inside {bsi_pkg::SH_IR, bsi_pkg::SH_DR} |=> tdo_oe_o) else $error("tdo not driven");
    a_upd_dr_holds: assert property (@(posedge sys_clk_i) disable iff (!rst_n_i)
        tck_rise && s_q.st == bsi_pkg::UPD_DR |=> $stable(s_q.bsr) && $stable(s_q.ir)) else $error("update-dr");
    a_bypass_zero: assert property (@(posedge sys_clk_i) disable iff (!rst_n_i)
        tck_rise && s_q.st == bsi_pkg::CAP_DR |=> !s_q.byp) else $error("bypass capture");
endmodule

// file: tb/bsi_ctl_model.sv
// board-side test controller model driving the scan pins
`timescale 1ns/1ps
module bsi_ctl_model (
    // system clock used to pace the pins
    input wire logic sys_clk_i,
    // scan pins
    output logic tck_o,
    output logic tms_o,
    output logic tdi_o,
    input wire logic tdo_i
);
    // ----------------------------------------
    // pin timing
    // ----------------------------------------
    // slow test clock
    // 16 system clocks a period: 6.25 MHz, and wide margin over the 3-flop sync
    localparam int HALF = 8;

    // idle: clock parked, pulled-up lines high
    initial begin
        tck_o = 1'b0;
        tms_o = 1'b1;
        tdi_o = 1'b1;
    end

    // one period, fall first; tdo read late in the high phase once settled
    task automatic step(input logic tms, input logic tdi, output logic tdo);
        tck_o <= 1'b0;
        tms_o <= tms;
        tdi_o <= tdi;
        repeat (HALF) @(posedge sys_clk_i);
        tck_o <= 1'b1;
        repeat (HALF - 2) @(posedge sys_clk_i);
        tdo = tdo_i;
        repeat (2) @(posedge sys_clk_i);
    endtask

    // state walk with tdi left at its pulled-up level
    task automatic go(input logic tms);
        logic d;
        step(tms, 1'b1, d);
    endtask

    // ----------------------------------------
    // scan sequences
    // ----------------------------------------
    // caller passes only the five defined codes
    task automatic ir_shift(input logic [2:0] code, output logic [2:0] cap);
        go(1'b1);
        go(1'b1);
        go(1'b0);
        go(1'b0);
        for (int i = 0; i < 3; i++) step(i == 2, code[i], cap[i]);
    endtask

    task automatic ir_update();
        go(1'b1);
        go(1'b0);
    endtask

    // capture, shift 80 bits lsb first, update, back to idle
    task automatic dr_scan(input logic [79:0] din, output logic [79:0] dout);
        go(1'b1);
        go(1'b0);
        go(1'b0);
        for (int i = 0; i < 80; i++) step(i == 79, din[i], dout[i]);
        go(1'b1);
        go(1'b0);
    endtask

    task automatic tlr();
        repeat (5) go(1'b1);
        go(1'b0);
    endtask
endmodule

// file: tb/tb_sram_boundary_scan_instruction_logic.sv
// self-checking bench for the boundary-scan instruction logic
`timescale 1ns/1ps
`include "bsi_params.svh"
`define CHK(nm, ex, gt) begin tests_run++; if ((gt) !== (ex)) begin err_total++; \
    $display("CHECK FAILED %s expected %h seen %h", nm, ex, gt); end end
module tb_sram_boundary_scan_instruction_logic;
    // ----------------------------------------
    // signals and constants
    // ----------------------------------------
    logic sys_clk_i;
    logic rst_n_i;
    logic wide_cfg_i;
    logic cap_ready_i;
    logic [`BSI_BSR_W-1:0] ring_i;
    logic tck_i, tms_i, tdi_i, tdo_o, tdo_oe_o, mem_hiz_o, cap_valid_o, cap_data_o;
    int err_total = 0;
    int tests_run = 0;
    int cap_idx = 0;
    int cap_cnt = 0;
    // ring held still so every captured bit, clock ball too, is stable
    localparam logic [72:0] RING = 73'h1_5c3f_01e2_d3c4_b5a6_97;
    localparam logic [79:0] DIN = 80'h3c5a_96f0_0ff1_e2d4_b789;
    // rows: code, selected length, expected output gate
    localparam logic [2:0] R_CODE [5] = '{3'h0, 3'h1, 3'h2, 3'h4, 3'h7};
    localparam int R_LEN [5] = '{73, 32, 73, 73, 1};
    localparam logic R_HIZ [5] = '{1'b1, 1'b0, 1'b1, 1'b0, 1'b0};

    bsi_tap dut_u (.sys_clk_i(sys_clk_i), .rst_n_i(rst_n_i), .tck_i(tck_i), .tms_i(tms_i),
        .tdi_i(tdi_i), .tdo_o(tdo_o), .tdo_oe_o(tdo_oe_o), .wide_cfg_i(wide_cfg_i),
        .ring_i(ring_i), .mem_hiz_o(mem_hiz_o), .cap_valid_o(cap_valid_o),
        .cap_ready_i(cap_ready_i), .cap_data_o(cap_data_o));
    // released tdo shows the opposite level, so a sample outside the drive window fails
    logic tdo_pin;
    assign tdo_pin = tdo_oe_o ? tdo_o : ~tdo_o;
    bsi_ctl_model ctl_u (.sys_clk_i(sys_clk_i), .tck_o(tck_i), .tms_o(tms_i), .tdi_o(tdi_i),
        .tdo_i(tdo_pin));

    // clock
    initial begin
        sys_clk_i = 1'b0;
        forever #5 sys_clk_i = ~sys_clk_i;
    end

    // captured stream must replay the ring lsb first
    always @(posedge sys_clk_i) begin
        if (!rst_n_i) begin
            cap_idx <= 0;
        end else if (cap_valid_o === 1'b1 && cap_ready_i) begin
            `CHK("cap_data", ring_i[cap_idx], cap_data_o);
            cap_idx <= (cap_idx + 1) % (wide_cfg_i ? 73 : 54);
            cap_cnt <= cap_cnt + 1;
        end
    end

    // ----------------------------------------
    // helpers
    // ----------------------------------------
    function automatic logic [79:0] cap_of(input int len);
        if (len == 32) return 80'(`BSI_ID_VALUE);
        if (len == 1) return '0;
        return 80'(ring_i);
    endfunction

    // selected register first, then tdi delayed by its length
    task automatic dr_run(input int len, input string nm);
        logic [79:0] got;
        logic [79:0] exp;
        logic [79:0] cap;
        cap = cap_of(len);
        for (int i = 0; i < 80; i++) exp[i] = (i < len) ? cap[i] : DIN[i - len];
        ctl_u.dr_scan(DIN, got);
        `CHK(nm, exp, got);
        `CHK("oe_idle", 1'b0, tdo_oe_o);
        $display("test %s done", nm);
    endtask

    task automatic complete_run();
        $display("comparisons %0d mismatches %0d", tests_run, err_total);
        if (err_total == 0 && tests_run > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask

    // hang guard
    initial begin
        repeat (100000) @(posedge sys_clk_i);
        err_total++;
        complete_run();
    end

    // ----------------------------------------
    // main sequence
    // ----------------------------------------
    initial begin
        logic [2:0] irc;
        logic prev_hiz;
        rst_n_i = 1'b0;
        wide_cfg_i = 1'b1;
        cap_ready_i = 1'b0;
        ring_i = RING;
        prev_hiz = 1'b0;
        repeat (4) @(posedge sys_clk_i);
        rst_n_i <= 1'b1;
        repeat (6) @(posedge sys_clk_i);
        ctl_u.go(1'b0);
        `CHK("hiz_powerup", 1'b0, mem_hiz_o);
        dr_run(32, "id_powerup");
        for (int k = 0; k < 5; k++) begin
            ctl_u.ir_shift(R_CODE[k], irc);
            `CHK("ir_capture", 2'h1, irc[1:0]);
            `CHK("ir_pending", prev_hiz, mem_hiz_o);
            ctl_u.ir_update();
            `CHK("hiz_gate", R_HIZ[k], mem_hiz_o);
            dr_run(R_LEN[k], "row_scan");
            `CHK("hiz_after_update", R_HIZ[k], mem_hiz_o);
            prev_hiz = R_HIZ[k];
            if (k == 0) begin
                `CHK("fifo_stalled", 1'b1, cap_valid_o);
                cap_ready_i <= 1'b1;
                for (int t = 0; t < 2000 && cap_cnt < 73; t++) @(posedge sys_clk_i);
                `CHK("fifo_drained", 73, cap_cnt);
            end
        end
        repeat (200) @(posedge sys_clk_i);
        `CHK("stream_words", 219, cap_cnt);
        ctl_u.ir_shift(3'h0, irc);
        ctl_u.ir_update();
        repeat (3) ctl_u.go(1'b1);
        `CHK("hiz_in_reset", 1'b0, mem_hiz_o);
        ctl_u.tlr();
        dr_run(32, "id_after_tms_reset");
        @(posedge sys_clk_i);
        rst_n_i <= 1'b0;
        wide_cfg_i <= 1'b0;
        @(posedge sys_clk_i);
        rst_n_i <= 1'b1;
        repeat (6) @(posedge sys_clk_i);
        ctl_u.go(1'b0);
        dr_run(32, "id_after_reset");
        ctl_u.ir_shift(3'h4, irc);
        ctl_u.ir_update();
        dr_run(54, "narrow_ring");
        `CHK("narrow_words", 273, cap_cnt);
        complete_run();
    end
endmodule
